// ---- hw/ism_pkg.sv ----
// constants, field layouts and helper functions of the interrupt service block
package ism_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NSRC = 11;
  localparam int IDX_W = 4;
  localparam int LVL_W = 3;
  localparam int TYPE_W = 5;
  // register offsets
  localparam logic [7:0] OFF_DONE_CMD = 8'h22;
  localparam logic [7:0] OFF_POLL_ACK = 8'h24;
  localparam logic [7:0] OFF_POLL_PEEK = 8'h26;
  localparam logic [7:0] OFF_SRC_MASK = 8'h28;
  localparam logic [7:0] OFF_FLOOR = 8'h2A;
  localparam logic [7:0] OFF_IN_SERVICE = 8'h2C;
  // reset values
  localparam logic [15:0] MASK_RST_MASTER = 16'h07FD;
  localparam logic [15:0] MASK_RST_SLAVE = 16'h003D;
  localparam logic [15:0] FLOOR_RST = 16'h0007;
  localparam logic [15:0] ISR_RST = 16'h0000;
  // implemented bits per mode
  localparam logic [10:0] VALID_MASTER = 11'h7FD;
  localparam logic [10:0] VALID_SLAVE = 11'h03D;
  // field positions
  localparam int PEND_BIT = 15;
  localparam int NSPEC_BIT = 15;
  localparam int BIT_TMR = 0;
  localparam int BIT_EXT0 = 4;
  localparam int BIT_EXT1 = 5;
  localparam int BIT_SLV_TIMER_ONE_SOURCE = 4;
  localparam int BIT_SLV_TIMER_TWO_SOURCE = 5;
  // cycles after synchronised reset release before mode is captured
  localparam logic [1:0] INIT_CYC = 2'h3;
  // interrupt type of each source index (master layout)
  function automatic logic [4:0] src_type(input logic [3:0] idx);
    case (idx)
      4'h0: src_type = 5'h08;
      4'h2: src_type = 5'h0A;
      4'h3: src_type = 5'h0B;
      4'h4: src_type = 5'h0C;
      4'h5: src_type = 5'h0D;
      4'h6: src_type = 5'h0E;
      4'h7: src_type = 5'h0F;
      4'h8: src_type = 5'h10;
      4'h9: src_type = 5'h11;
      4'hA: src_type = 5'h14;
      default: src_type = 5'h1F;
    endcase
  endfunction
  function automatic logic [2:0] lvl_of(input logic [32:0] lv,
                                        input int idx);
    lvl_of = lv[idx*3 +: 3];
  endfunction
  function automatic logic [10:0] valid_bits(input logic slave);
    valid_bits = slave ? VALID_SLAVE : VALID_MASTER;
  endfunction
endpackage

// ---- hw/ism_reg_if.sv ----
// decoded register strobes and read words between bus slave and core logic
`timescale 1ns/1ps
`default_nettype none
interface ism_reg_if;
  logic wr_done;
  logic wr_mask;
  logic wr_floor;
  logic rd_poll;
  logic rd_peek;
  logic [15:0] wdata;
  logic [15:0] poll_word;
  logic [15:0] mask_word;
  logic [15:0] floor_word;
  logic [15:0] isr_word;
  modport bus (output wr_done, wr_mask, wr_floor, rd_poll, rd_peek, wdata,
               input poll_word, mask_word, floor_word, isr_word);
  modport core (input wr_done, wr_mask, wr_floor, rd_poll, rd_peek, wdata,
                output poll_word, mask_word, floor_word, isr_word);
endinterface
`default_nettype wire

// ---- hw/ism_prio.sv ----
// picks the candidate with the numerically lowest level, lowest index on ties
`timescale 1ns/1ps
`default_nettype none
module ism_prio (
  // candidates
  input wire logic [10:0] cand,
  input wire logic [32:0] levels,
  // winner
  output logic valid,
  output logic [3:0] idx,
  output logic [2:0] level
);
  always_comb begin
    valid = 1'b0;
    idx = 4'h0;
    level = 3'h7;
    for (int i = 0; i < ism_pkg::NSRC; i++) begin
      if (cand[i] && (!valid || ism_pkg::lvl_of(levels, i) < level)) begin
        valid = 1'b1;
        idx = 4'(i);
        level = ism_pkg::lvl_of(levels, i);
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/ism_busif.sv ----
// register bus slave: address decode and registered read data
`timescale 1ns/1ps
`default_nettype none
module ism_busif (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // core side
  ism_reg_if.bus rif
);
  // poll registers and in-service are read-only, writes there fall away
  assign rif.wr_done = wr && addr == ism_pkg::OFF_DONE_CMD;
  assign rif.wr_mask = wr && addr == ism_pkg::OFF_SRC_MASK;
  assign rif.wr_floor = wr && addr == ism_pkg::OFF_FLOOR;
  assign rif.rd_poll = rd && addr == ism_pkg::OFF_POLL_ACK;
  assign rif.rd_peek = rd && addr == ism_pkg::OFF_POLL_PEEK;
  assign rif.wdata = wdata;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        ism_pkg::OFF_POLL_ACK: rdata <= rif.poll_word;
        ism_pkg::OFF_POLL_PEEK: rdata <= rif.poll_word;
        ism_pkg::OFF_SRC_MASK: rdata <= rif.mask_word;
        ism_pkg::OFF_FLOOR: rdata <= rif.floor_word;
        ism_pkg::OFF_IN_SERVICE: rdata <= rif.isr_word;
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- hw/ism_top.sv ----
// in-service flags, priority floor, source mask and poll registers
`timescale 1ns/1ps
`default_nettype none
// Function
// - taking an interrupt sets the in-service flag of its source
// - a service-done command naming the interrupt clears its in-service flag
// - a set in-service flag blocks new requests from that source
// - special fully nested mode exempts external lines zero and one
// - master in-service: serial 10, watchdog 9, ext 8-4, dma 3:2, timer 0
// - master timer-group in-service bit is the OR of three timer states
// - slave in-service: timer2 bit 5, timer1 bit 4, dma 3:2, timer0 bit 0
// - slave internal request sets its bit, the internal acknowledge clears it
// - priority floor in both modes, bits 2-0, resets to seven, rest zero
// - requests with level numerically above the floor are blocked
// - level 0 is highest, 7 lowest; floor 7 passes every unmasked source
// - mask readable and writable, one masks, same as control mask bit
// - master mask resets to 07FD, same layout as master in-service
// - slave mask resets to 003D, mirrors control mask bits
// - reading poll peek returns poll contents and changes nothing
// - reading poll acknowledges current interrupt, next pending replaces it
// - bit 15 shows a pending interrupt; bits 4-0 then give its type
// - poll acknowledge starts no handler; software branches itself
// - both poll registers are read-only, writes ignored
// - master done command: bit 15 non-specific, else type in bits 4-0
// - slave done command: level in bits 2-0 clears that level's flag
// - control register mask bit and mask register bit always agree
module ism_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // mode straps
  input wire logic SLAVE_MODE,
  input wire logic NESTED_MODE,
  // request sources
  input wire logic [10:0] SRC_REQ,
  input wire logic [2:0] TMR_REQ,
  input wire logic [32:0] SRC_LEVEL,
  // control register mask bit path
  input wire logic [10:0] CTL_MASK_WR,
  input wire logic [10:0] CTL_MASK_VAL,
  output logic [10:0] MASK_VIEW,
  // core side
  input wire logic TAKE_ACK,
  output logic INT_REQ,
  output logic [4:0] INT_TYPE,
  output logic [10:0] IN_SERVICE
);
  logic rst_s1_q;
  logic rst_n_q;
  logic slave_s1_q;
  logic slave_s2_q;
  logic nest_s1_q;
  logic nest_s2_q;
  logic [1:0] init_cnt_q;
  logic ready_q;
  logic slave_q;
  logic [10:0] mask_q;
  logic [10:0] mask_d;
  logic [2:0] floor_q;
  logic [10:0] isr_q;
  logic [10:0] isr_d;
  logic [2:0] tmr_isr_q;
  logic [10:0] pend_q;
  logic poll_vld_q;
  logic [3:0] poll_idx_q;
  logic [4:0] poll_type_q;
  logic [2:0] poll_lvl_q;
  logic [10:0] valid;
  logic [10:0] req_vec;
  logic [10:0] pending;
  logic [10:0] isr_view;
  logic [10:0] blocked;
  logic [10:0] elig;
  logic [10:0] take_oh;
  logic [10:0] set_vec;
  logic [10:0] clr_vec;
  logic take;
  logic win_vld;
  logic [3:0] win_idx;
  logic [2:0] win_lvl;
  logic hi_vld;
  logic [3:0] hi_idx;
  logic [2:0] hi_lvl;

  ism_reg_if rif ();

  ism_busif u_bus (
    .clk(REF_CLK),
    .rst_n(rst_n_q),
    .addr(ADDR),
    .wdata(WDATA),
    .wr(WR),
    .rd(RD),
    .rdata(RDATA),
    .rif(rif.bus)
  );

  // reset release through two flops
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // straps are pins, so they are synchronised before use
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      slave_s1_q <= 1'b0;
      slave_s2_q <= 1'b0;
      nest_s1_q <= 1'b0;
      nest_s2_q <= 1'b0;
    end else begin
      slave_s1_q <= SLAVE_MODE;
      slave_s2_q <= slave_s1_q;
      nest_s1_q <= NESTED_MODE;
      nest_s2_q <= nest_s1_q;
    end
  end

  // slave mode is caught once after release; changing it later has no effect, nested mode follows its synchronised strap
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      init_cnt_q <= 2'h0;
      ready_q <= 1'b0;
      slave_q <= 1'b0;
    end else if (!ready_q) begin
      init_cnt_q <= init_cnt_q + 2'h1;
      if (init_cnt_q == ism_pkg::INIT_CYC - 2'h1) begin
        ready_q <= 1'b1;
        slave_q <= slave_s2_q;
      end
    end
  end

  assign valid = ism_pkg::valid_bits(slave_q);

  // slave layout reuses bits 4 and 5 for timers one and two
  always_comb begin
    req_vec = SRC_REQ & valid;
    if (slave_q) begin
      req_vec[ism_pkg::BIT_TMR] = TMR_REQ[0];
      req_vec[ism_pkg::BIT_SLV_TIMER_ONE_SOURCE] = TMR_REQ[1];
      req_vec[ism_pkg::BIT_SLV_TIMER_TWO_SOURCE] = TMR_REQ[2];
    end else begin
      req_vec[ism_pkg::BIT_TMR] = |TMR_REQ;
    end
  end

  assign take = (TAKE_ACK || rif.rd_poll) && poll_vld_q && ready_q;
  assign take_oh = take ? (11'h001 << poll_idx_q) : 11'h000;

  // slave requests are latched events; the set wins over the acknowledge
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q <= 11'h000;
    end else if (slave_q) begin
      pend_q <= ((pend_q & ~take_oh) | req_vec) & valid;
    end else begin
      pend_q <= 11'h000;
    end
  end

  assign pending = slave_q ? pend_q : req_vec;

  // master timer bit reads as the OR of the three timer flags
  always_comb begin
    isr_view = isr_q & valid;
    if (!slave_q) begin
      isr_view[ism_pkg::BIT_TMR] = |tmr_isr_q;
    end
  end

  always_comb begin
    for (int i = 0; i < ism_pkg::NSRC; i++) begin
      blocked[i] = isr_view[i];
    end
    if (!slave_q && nest_s2_q) begin
      blocked[ism_pkg::BIT_EXT0] = 1'b0;
      blocked[ism_pkg::BIT_EXT1] = 1'b0;
    end
  end

  // the source just taken is left out so the poll word moves on at once
  always_comb begin
    for (int i = 0; i < ism_pkg::NSRC; i++) begin
      elig[i] = pending[i] && valid[i] && !mask_q[i]
        && ism_pkg::lvl_of(SRC_LEVEL, i) <= floor_q
        && !blocked[i] && !take_oh[i] && ready_q;
    end
  end

  ism_prio u_win (
    .cand(elig),
    .levels(SRC_LEVEL),
    .valid(win_vld),
    .idx(win_idx),
    .level(win_lvl)
  );

  ism_prio u_hi (
    .cand(isr_view),
    .levels(SRC_LEVEL),
    .valid(hi_vld),
    .idx(hi_idx),
    .level(hi_lvl)
  );

  // poll contents; a peek read does not touch them
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      poll_vld_q <= 1'b0;
      poll_idx_q <= 4'h0;
      poll_type_q <= 5'h00;
      poll_lvl_q <= 3'h7;
    end else begin
      poll_vld_q <= win_vld;
      poll_idx_q <= win_idx;
      poll_type_q <= win_vld ? ism_pkg::src_type(win_idx) : 5'h00;
      poll_lvl_q <= win_lvl;
    end
  end

  // service-done command decode
  always_comb begin
    clr_vec = 11'h000;
    if (rif.wr_done) begin
      if (slave_q) begin
        for (int i = 0; i < ism_pkg::NSRC; i++) begin
          if (ism_pkg::lvl_of(SRC_LEVEL, i) == rif.wdata[2:0]) begin
            clr_vec[i] = valid[i];
          end
        end
      end else if (rif.wdata[ism_pkg::NSPEC_BIT]) begin
        if (hi_vld) begin
          clr_vec = 11'h001 << hi_idx;
        end
      end else begin
        for (int i = 0; i < ism_pkg::NSRC; i++) begin
          if (ism_pkg::src_type(4'(i)) == rif.wdata[4:0]) begin
            clr_vec[i] = valid[i];
          end
        end
      end
    end
  end

  assign set_vec = take_oh & valid;
  // a flag set in the same cycle as its clear stays set
  assign isr_d = (isr_q & ~clr_vec) | set_vec;

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      isr_q <= ism_pkg::ISR_RST[10:0];
    end else begin
      isr_q <= isr_d;
    end
  end

  // per-timer flags behind the master group bit
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tmr_isr_q <= 3'h0;
    end else if (slave_q) begin
      tmr_isr_q <= 3'h0;
    end else if (set_vec[ism_pkg::BIT_TMR]) begin
      tmr_isr_q <= tmr_isr_q | (TMR_REQ & ~(TMR_REQ - 3'h1));
    end else if (clr_vec[ism_pkg::BIT_TMR]) begin
      tmr_isr_q <= 3'h0;
    end
  end

  // one stored bit serves both views; control register write wins a tie
  always_comb begin
    mask_d = mask_q;
    if (rif.wr_mask) begin
      mask_d = rif.wdata[10:0] & valid;
    end
    for (int i = 0; i < ism_pkg::NSRC; i++) begin
      if (CTL_MASK_WR[i] && valid[i]) begin
        mask_d[i] = CTL_MASK_VAL[i];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= ism_pkg::MASK_RST_MASTER[10:0];
    end else if (!ready_q) begin
      if (init_cnt_q == ism_pkg::INIT_CYC - 2'h1) begin
        mask_q <= slave_s2_q ? ism_pkg::MASK_RST_SLAVE[10:0]
                             : ism_pkg::MASK_RST_MASTER[10:0];
      end
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      floor_q <= ism_pkg::FLOOR_RST[2:0];
    end else if (rif.wr_floor) begin
      floor_q <= rif.wdata[2:0];
    end
  end

  // read words; unused bits read as zero
  assign rif.poll_word = {poll_vld_q, 10'h000, poll_type_q};
  assign rif.mask_word = {5'h00, mask_q};
  assign rif.floor_word = {13'h0000, floor_q};
  assign rif.isr_word = {5'h00, isr_view};

  // a poll acknowledge only raises flags; the handler jump is software's
  assign MASK_VIEW = mask_q;
  assign IN_SERVICE = isr_view;
  assign INT_REQ = poll_vld_q;
  assign INT_TYPE = poll_type_q;

  chk_take_sets_flag: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) take && !clr_vec[poll_idx_q]
    |=> isr_q[$past(poll_idx_q)])
    else $error("taken source has no in-service flag");

  chk_done_clears: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) rif.wr_done && !slave_q
    && !rif.wdata[15] && rif.wdata[4:0] == 5'h0C && !take
    |=> !isr_q[4])
    else $error("specific done command left flag set");

  chk_flag_blocks: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) poll_vld_q && !(!slave_q && nest_s2_q
    && (poll_idx_q == 4'h4 || poll_idx_q == 4'h5))
    |-> ##1 !(isr_view[poll_idx_q] && $stable(isr_view)
    && poll_vld_q && $past(isr_view[poll_idx_q])))
    else $error("in-service source polled again");

  chk_mask_blocks: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) win_vld |-> !mask_q[win_idx])
    else $error("masked source wins");

  chk_floor_blocks: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) poll_vld_q |-> $past(floor_q) >= poll_lvl_q)
    else $error("source above floor polled");

  chk_peek_quiet: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) rif.rd_peek && !TAKE_ACK && clr_vec == 11'h000
    |=> isr_q == $past(isr_q))
    else $error("peek read changed in-service state");

  chk_poll_ro: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) WR && (ADDR == 8'h24 || ADDR == 8'h26)
    && CTL_MASK_WR == 11'h000
    |=> $stable(mask_q) && $stable(floor_q))
    else $error("write to poll register had an effect");

  chk_poll_word: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) rif.rd_poll
    |=> RDATA[15] == $past(poll_vld_q) && RDATA[14:5] == 10'h000)
    else $error("poll read data wrong");

  chk_timer_or: assert property (@(posedge REF_CLK)
    disable iff (!rst_n_q) !slave_q |-> IN_SERVICE[0] == |tmr_isr_q)
    else $error("timer group bit differs from timer flags");
endmodule
`default_nettype wire

// ---- verification/ism_src_model.sv ----
// request sources that stand in front of the interrupt service block
`timescale 1ns/1ps
`default_nettype none
module ism_src_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control from the bench
  input wire logic slave,
  input wire logic [10:0] hold,
  input wire logic [2:0] thold,
  // request lines
  output logic [10:0] src_req,
  output logic [2:0] tmr_req
);
  logic [10:0] hold_q;
  logic [2:0] thold_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 11'h000;
      thold_q <= 3'h0;
    end else begin
      hold_q <= hold;
      thold_q <= thold;
    end
  end
  // slave sources fire one event per rising request, master holds a level
  always_comb begin
    if (slave) begin
      src_req = hold & ~hold_q;
      tmr_req = thold & ~thold_q;
    end else begin
      src_req = hold;
      tmr_req = thold;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_ism_top.sv ----
// self-checking bench of the interrupt service block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  failures++; $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); \
  end end
module test_ism_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic slave = 1'b0;
  logic nested = 1'b0;
  logic [10:0] hold = 11'h000;
  logic [2:0] thold = 3'h0;
  logic [10:0] src_req;
  logic [2:0] tmr_req;
  logic [32:0] level = 33'h1FFFFFFFF;
  logic [10:0] ctl_wr = 11'h000;
  logic [10:0] ctl_val = 11'h000;
  logic [10:0] mask_view;
  logic take = 1'b0;
  logic int_req;
  logic [4:0] int_type;
  logic [10:0] in_service;
  logic [15:0] d;
  int failures = 0;
  int check_count = 0;
  typedef struct {
    logic [7:0] a;
    logic [15:0] wd;
    logic w;
    logic [15:0] exp;
  } ism_row_t;
  ism_row_t rows [11] = '{
    '{8'h28, 16'h0000, 1'b0, 16'h07FD}, '{8'h2A, 16'h0000, 1'b0, 16'h0007},
    '{8'h2C, 16'h0000, 1'b0, 16'h0000}, '{8'h26, 16'h0000, 1'b0, 16'h0000},
    '{8'h28, 16'hFFFF, 1'b1, 16'h07FD}, '{8'h28, 16'h07EC, 1'b1, 16'h07EC},
    '{8'h2A, 16'hFFF4, 1'b1, 16'h0004}, '{8'h24, 16'h1234, 1'b1, 16'h0000},
    '{8'h26, 16'h5678, 1'b1, 16'h0000}, '{8'h2C, 16'h0FFF, 1'b1, 16'h0000},
    '{8'h30, 16'hFFFF, 1'b1, 16'h0000}};
  always #5 clk = ~clk;
  ism_src_model model (.clk(clk), .rst_n(rst_n), .slave(slave), .hold(hold),
    .thold(thold), .src_req(src_req), .tmr_req(tmr_req));
  ism_top dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SLAVE_MODE(slave),
    .NESTED_MODE(nested), .SRC_REQ(src_req), .TMR_REQ(tmr_req),
    .SRC_LEVEL(level), .CTL_MASK_WR(ctl_wr), .CTL_MASK_VAL(ctl_val),
    .MASK_VIEW(mask_view), .TAKE_ACK(take), .INT_REQ(int_req),
    .INT_TYPE(int_type), .IN_SERVICE(in_service));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(6);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // the whole run is about 130 cycles, so this bound is generous
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr_reg(rows[i].a, rows[i].wd);
      end
      rd_reg(rows[i].a, d);
      `CHK(d, rows[i].exp)
    end
    // external line zero at level 5 against floor 4
    level[14:12] <= 3'h5;
    hold <= 11'h010;
    cyc(4);
    `CHK(int_req, 1'b0)
    wr_reg(8'h2A, 16'h0005);
    cyc(4);
    rd_reg(8'h26, d);
    `CHK(d, 16'h800C)
    `CHK(in_service, 11'h000)
    rd_reg(8'h24, d);
    `CHK(d, 16'h800C)
    `CHK(in_service, 11'h010)
    cyc(3);
    `CHK(int_req, 1'b0)
    wr_reg(8'h22, 16'h000C);
    cyc(3);
    `CHK(in_service, 11'h000)
    `CHK(int_req, 1'b1)
    // nested mode lets the line interrupt itself
    nested <= 1'b1;
    cyc(4);
    rd_reg(8'h24, d);
    cyc(3);
    `CHK(int_req, 1'b1)
    `CHK(in_service, 11'h010)
    nested <= 1'b0;
    hold <= 11'h000;
    wr_reg(8'h22, 16'h8000);
    cyc(3);
    `CHK(in_service, 11'h000)
    // timer group taken through the core acknowledge
    wr_reg(8'h2A, 16'h0007);
    thold <= 3'h2;
    cyc(4);
    `CHK(int_type, 5'h08)
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    cyc(2);
    `CHK(in_service, 11'h001)
    thold <= 3'h0;
    wr_reg(8'h22, 16'h0008);
    cyc(3);
    `CHK(in_service, 11'h000)
    // control mask path beats a bus write in the same cycle
    @(posedge clk);
    ctl_wr <= 11'h200;
    ctl_val <= 11'h000;
    addr <= 8'h28;
    wdata <= 16'h07FF;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    ctl_wr <= 11'h000;
    rd_reg(8'h28, d);
    `CHK(d, 16'h05FD)
    `CHK(mask_view, 11'h5FD)
    // slave mode after a second reset
    slave <= 1'b1;
    do_reset();
    rd_reg(8'h28, d);
    `CHK(d, 16'h003D)
    rd_reg(8'h2A, d);
    `CHK(d, 16'h0007)
    wr_reg(8'h28, 16'h0000);
    thold <= 3'h4;
    cyc(4);
    rd_reg(8'h24, d);
    `CHK(d, 16'h800D)
    `CHK(in_service, 11'h020)
    cyc(3);
    `CHK(int_req, 1'b0)
    wr_reg(8'h22, 16'h0007);
    cyc(3);
    `CHK(in_service, 11'h000)
    `CHK(int_req, 1'b0)
    end_sim();
  end
endmodule
`default_nettype wire
